// [core/fwsc_top.sv]
// Protection status and control registers with fault pin and output gating
// How it works
// - Thermal shutdown latches flag, tristates output, reports
// - Thermal flag stays set until clear write
// - Auto-recovery resumes once overheating has gone
// - Auto-recovery bit enables recovery, resets to zero
// - Channel limit fault sets its status bit
// - Channel limit warning sets its warning bit
// - Four thermal warning levels reported separately
// - Report mask register masks one source each
// - Latch enables per group default on; clock detect latch enable defaults off
// - Warning and limit report masks default off
// - Clock detect status latched only when enabled
// - Level field selects limit fraction, 11 reserved
// - Limiting works only while function enabled
// - Warnings and faults need their own enables
// - Limit fault enable resets to zero
// - Writing one to clear bit clears faults
// - Offset and overcurrent faults latch and tristate
`timescale 1ns/100ps
module fwsc_top
	import fwsc_pkg::*;
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	// Register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic [7:0] regWrData,
	input  wire logic       regRead,
	output logic      [7:0] regRdData_q,
	output logic            regRdValid_q,
	// Live protection conditions
	input  wire logic       thermShutdownIn,
	input  wire logic [3:0] thermWarnIn,
	input  wire logic [1:0] chanLimitFaultIn,
	input  wire logic [1:0] chanLimitWarnIn,
	input  wire logic       clockErrorIn,
	input  wire logic       clockDetectIn,
	input  wire logic [1:0] chanOffsetFaultIn,
	input  wire logic [1:0] chanOverCurrentIn,
	input  wire logic       logicSupplyUnderIn,
	input  wire logic       logicSupplyOverIn,
	input  wire logic       powerSupplyUnderIn,
	input  wire logic       powerSupplyOverIn,
	// Fault pin and output stage
	output logic            faultReport_q,
	output logic            outputHiZ_q,
	// Current limiter controls
	output logic            limitFunctionEnable_q,
	output logic            limitWarningEnable_q,
	output logic            limitFaultEnable_q,
	output logic      [1:0] limitLevelSelect_q,
	// Clock detection status
	output logic            clockDetectStatus_q
);
	import fwsc_pkg::*;

	typedef struct packed {
		logic [7:0] reportMask;
		logic [7:0] latchCtl;
		logic [7:0] recoveryCtl;
		logic [7:0] limitCtl;
		logic       thermHold;
		logic       faultReport;
		logic       hiZ;
		logic [7:0] rdData;
		logic       rdValid;
	} fwsc_state_t;

	localparam fwsc_state_t RESET_STATE = '{
		reportMask:  RST_REPORT_MASK,
		latchCtl:    RST_LATCH_CTL,
		recoveryCtl: RST_RECOVERY_CTL,
		limitCtl:    RST_LIMIT_CTL,
		thermHold:   1'b0,
		faultReport: 1'b0,
		hiZ:         1'b0,
		rdData:      READ_ZERO,
		rdValid:     1'b0
	};

	fwsc_state_t            s_d;
	fwsc_state_t            s_q;
	logic [NUM_FLAGS-1:0]   liveVec;
	logic [NUM_FLAGS-1:0]   latchVec;
	logic [NUM_FLAGS-1:0]   flag_q;
	logic                   faultClear;
	logic                   limitOn;

	function automatic logic wrHit(input logic [7:0] addr,
		input logic [7:0] target, input logic wr);
		wrHit = wr && (addr == target);
	endfunction

	function automatic logic [7:0] readMux(input logic [7:0] addr,
		input fwsc_state_t st, input logic [NUM_FLAGS-1:0] fl);
		case (addr)
			ADDR_FAULT_STATUS: readMux = {5'h0, fl[FLG_LF2],
				fl[FLG_LF1], fl[FLG_THERM]};
			ADDR_WARN_STATUS:  readMux = {2'h0, fl[FLG_LW1], fl[FLG_LW2],
				fl[FLG_TW_HI:FLG_TW_LO]};
			ADDR_REPORT_MASK:  readMux = st.reportMask;
			ADDR_LATCH_CTL:    readMux = st.latchCtl;
			ADDR_RECOVERY_CTL: readMux = st.recoveryCtl;
			ADDR_LIMIT_CTL:    readMux = st.limitCtl;
			default:           readMux = READ_ZERO;
		endcase
	endfunction

	assign faultClear = wrHit(regAddr, ADDR_FAULT_CLEAR, regWrite)
		&& regWrData[FAULT_CLEAR_BIT];

	// Limiter events only count while the limiter itself runs
	assign limitOn = s_q.limitCtl[LIM_FUNCTION_EN];

	always_comb begin
		liveVec = '0;
		latchVec = '0;
		liveVec[FLG_THERM] = thermShutdownIn;
		latchVec[FLG_THERM] = s_q.latchCtl[LEN_SHUTDOWN];
		liveVec[FLG_LF1] = chanLimitFaultIn[0] && limitOn
			&& s_q.limitCtl[LIM_FAULT_EN];
		liveVec[FLG_LF2] = chanLimitFaultIn[1] && limitOn
			&& s_q.limitCtl[LIM_FAULT_EN];
		latchVec[FLG_LF1] = s_q.latchCtl[LEN_LIMIT_FAULT];
		latchVec[FLG_LF2] = s_q.latchCtl[LEN_LIMIT_FAULT];
		liveVec[FLG_LW1] = chanLimitWarnIn[0] && limitOn
			&& s_q.limitCtl[LIM_WARNING_EN];
		liveVec[FLG_LW2] = chanLimitWarnIn[1] && limitOn
			&& s_q.limitCtl[LIM_WARNING_EN];
		latchVec[FLG_LW1] = s_q.latchCtl[LEN_LIMIT_WARN];
		latchVec[FLG_LW2] = s_q.latchCtl[LEN_LIMIT_WARN];
		liveVec[FLG_TW_HI:FLG_TW_LO] = thermWarnIn;
		latchVec[FLG_TW_HI:FLG_TW_LO] = {4{s_q.latchCtl[LEN_THERM_WARN]}};
		liveVec[FLG_CLOCK] = clockErrorIn;
		latchVec[FLG_CLOCK] = s_q.latchCtl[LEN_CLOCK_FAULT];
		liveVec[FLG_DC2:FLG_DC1] = chanOffsetFaultIn;
		liveVec[FLG_OC2:FLG_OC1] = chanOverCurrentIn;
		latchVec[FLG_OC2:FLG_DC1] = 4'hF;
		liveVec[FLG_CDET] = clockDetectIn;
		latchVec[FLG_CDET] = s_q.recoveryCtl[RCV_CLOCK_DETECT_LATCH];
	end

	fwsc_flag_cell #(
		.WIDTH    (NUM_FLAGS)
	) u_flags (
		.ref_clk  (ref_clk),
		.nrst     (nrst),
		.liveIn   (liveVec),
		.latchEn  (latchVec),
		.clearReq (faultClear),
		.flag_q   (flag_q)
	);

	always_comb begin
		s_d = s_q;
		if (wrHit(regAddr, ADDR_REPORT_MASK, regWrite)) begin
			s_d.reportMask = regWrData;
		end
		if (wrHit(regAddr, ADDR_LATCH_CTL, regWrite)) begin
			s_d.latchCtl = regWrData;
		end
		if (wrHit(regAddr, ADDR_RECOVERY_CTL, regWrite)) begin
			s_d.recoveryCtl = regWrData & WMASK_RECOVERY;
		end
		if (wrHit(regAddr, ADDR_LIMIT_CTL, regWrite)) begin
			s_d.limitCtl = regWrData & WMASK_LIMIT;
			// A reserved level code would leave the threshold undefined
			if (regWrData[LIM_LEVEL_HI:LIM_LEVEL_LO] == LEVEL_RESERVED) begin
				s_d.limitCtl[LIM_LEVEL_HI:LIM_LEVEL_LO] =
					s_q.limitCtl[LIM_LEVEL_HI:LIM_LEVEL_LO];
			end
		end
		// Output stays off until recovery or a clear; a new event wins
		if (thermShutdownIn) begin
			s_d.thermHold = 1'b1;
		end else if (faultClear) begin
			s_d.thermHold = 1'b0;
		end else if (s_q.recoveryCtl[RCV_SHUTDOWN_AUTO]) begin
			s_d.thermHold = 1'b0;
		end
		s_d.hiZ = s_d.thermHold | (|chanOffsetFaultIn)
			| (|chanOverCurrentIn) | (|flag_q[FLG_OC2:FLG_DC1]);
		s_d.faultReport =
			(flag_q[FLG_THERM] && !s_q.reportMask[MSK_THERM_SHUTDOWN])
			|| (logicSupplyUnderIn && !s_q.reportMask[MSK_LOGIC_UNDER])
			|| (logicSupplyOverIn && !s_q.reportMask[MSK_LOGIC_OVER])
			|| (flag_q[FLG_CLOCK] && !s_q.reportMask[MSK_CLOCK_ERROR])
			|| (powerSupplyUnderIn && !s_q.reportMask[MSK_POWER_UNDER])
			|| (powerSupplyOverIn && !s_q.reportMask[MSK_POWER_OVER])
			|| ((|flag_q[FLG_DC2:FLG_DC1])
				&& !s_q.reportMask[MSK_OFFSET_FAULT])
			|| ((|flag_q[FLG_OC2:FLG_OC1])
				&& !s_q.reportMask[MSK_OVERCURRENT])
			|| ((|flag_q[FLG_TW_HI:FLG_TW_LO])
				&& !s_q.latchCtl[MSK_THERM_WARNING])
			|| ((|flag_q[FLG_LW2:FLG_LW1])
				&& !s_q.latchCtl[MSK_LIMIT_WARNING])
			|| ((|flag_q[FLG_LF2:FLG_LF1])
				&& !s_q.latchCtl[MSK_LIMIT_FAULT]);
		s_d.rdValid = regRead;
		s_d.rdData = regRead ? readMux(regAddr, s_q, flag_q) : READ_ZERO;
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	assign regRdData_q           = s_q.rdData;
	assign regRdValid_q          = s_q.rdValid;
	assign faultReport_q         = s_q.faultReport;
	assign outputHiZ_q           = s_q.hiZ;
	assign limitFunctionEnable_q = s_q.limitCtl[LIM_FUNCTION_EN];
	assign limitWarningEnable_q  = s_q.limitCtl[LIM_WARNING_EN];
	assign limitFaultEnable_q    = s_q.limitCtl[LIM_FAULT_EN];
	assign limitLevelSelect_q    = s_q.limitCtl[LIM_LEVEL_HI:LIM_LEVEL_LO];
	assign clockDetectStatus_q   = flag_q[FLG_CDET];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	sequence clearWriteSeq;
		regWrite && (regAddr == ADDR_FAULT_CLEAR)
			&& regWrData[FAULT_CLEAR_BIT];
	endsequence

	sequence shutdownSeq;
		thermShutdownIn ##1 !thermShutdownIn;
	endsequence

	shutdown_set_a: assert property (
		thermShutdownIn |=> flag_q[FLG_THERM] && outputHiZ_q)
		else $error("shutdown did not latch flag and tristate");
	shutdown_hold_a: assert property (
		flag_q[FLG_THERM] && s_q.latchCtl[LEN_SHUTDOWN] && !faultClear
		|=> flag_q[FLG_THERM])
		else $error("shutdown flag dropped without clear");
	clear_write_a: assert property (
		clearWriteSeq ##0 !thermShutdownIn |=> !flag_q[FLG_THERM])
		else $error("fault clear write did not clear shutdown flag");
	auto_recover_a: assert property (
		shutdownSeq ##0 (s_q.recoveryCtl[RCV_SHUTDOWN_AUTO]
			&& !thermShutdownIn) |=> !s_q.thermHold)
		else $error("auto recovery did not release output");
	no_recover_a: assert property (
		s_q.thermHold && !s_q.recoveryCtl[RCV_SHUTDOWN_AUTO] && !faultClear
		|=> s_q.thermHold)
		else $error("output released without auto recovery");
	limit_gate_a: assert property (
		$rose(flag_q[FLG_LF1]) |-> $past(limitFunctionEnable_q
			&& limitFaultEnable_q))
		else $error("limit fault flagged while disabled");
	warn_gate_a: assert property (
		$rose(flag_q[FLG_LW2]) |-> $past(limitFunctionEnable_q
			&& limitWarningEnable_q))
		else $error("limit warning flagged while disabled");
	fault_pin_a: assert property (
		flag_q[FLG_THERM] && !s_q.reportMask[MSK_THERM_SHUTDOWN]
		|=> faultReport_q)
		else $error("unmasked shutdown not reported on pin");
	track_live_a: assert property (
		!s_q.latchCtl[LEN_SHUTDOWN] && !thermShutdownIn
		|=> !flag_q[FLG_THERM])
		else $error("unlatched shutdown flag did not follow condition");
	offset_hiz_a: assert property (
		(|chanOffsetFaultIn) |=> outputHiZ_q ##1 outputHiZ_q)
		else $error("offset fault did not tristate output");
	reserved_read_a: assert property (
		regRead && (regAddr == ADDR_FAULT_STATUS)
		|=> regRdValid_q && (regRdData_q[7:3] == 5'h0))
		else $error("reserved status bits read non-zero");
	limit_set_a: assert property (
		chanLimitFaultIn[1] && limitFunctionEnable_q
		&& limitFaultEnable_q
		|=> flag_q[FLG_LF2])
		else $error("channel limit fault not flagged");
	warn_set_a: assert property (
		chanLimitWarnIn[0] && limitFunctionEnable_q
		&& limitWarningEnable_q
		|=> flag_q[FLG_LW1])
		else $error("channel limit warning not flagged");
	therm_warn_a: assert property (
		(thermWarnIn != 4'h0) |=> ((flag_q[FLG_TW_HI:FLG_TW_LO]
			& $past(thermWarnIn)) == $past(thermWarnIn)))
		else $error("thermal warning level not flagged");
	supply_pin_a: assert property (
		powerSupplyUnderIn && !s_q.reportMask[MSK_POWER_UNDER]
		|=> faultReport_q)
		else $error("unmasked supply fault not reported on pin");
	detect_latch_a: assert property (
		clockDetectStatus_q && s_q.recoveryCtl[RCV_CLOCK_DETECT_LATCH]
		&& !faultClear |=> clockDetectStatus_q)
		else $error("latched clock detect status dropped");
	level_keep_a: assert property (
		regWrite && (regAddr == ADDR_LIMIT_CTL)
		&& (regWrData[LIM_LEVEL_HI:LIM_LEVEL_LO] == LEVEL_RESERVED)
		|=> $stable(limitLevelSelect_q))
		else $error("reserved limit level code was taken");
	recovery_read_a: assert property (
		regRead && (regAddr == ADDR_RECOVERY_CTL)
		|=> (regRdData_q & ~WMASK_RECOVERY) == 8'h00)
		else $error("reserved recovery bits read non-zero");

endmodule

// [core/fwsc_pkg.sv]
// Register map, field positions and flag indices of the protection slice
package fwsc_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_FAULT_STATUS  = 8'h72;
	localparam logic [7:0] ADDR_WARN_STATUS   = 8'h73;
	localparam logic [7:0] ADDR_REPORT_MASK   = 8'h74;
	localparam logic [7:0] ADDR_LATCH_CTL     = 8'h75;
	localparam logic [7:0] ADDR_RECOVERY_CTL  = 8'h76;
	localparam logic [7:0] ADDR_LIMIT_CTL     = 8'h77;
	localparam logic [7:0] ADDR_FAULT_CLEAR   = 8'h78;

	// Reset values and writable bits
	localparam logic [7:0] RST_REPORT_MASK    = 8'h00;
	localparam logic [7:0] RST_LATCH_CTL      = 8'hF8;
	localparam logic [7:0] RST_RECOVERY_CTL   = 8'h00;
	localparam logic [7:0] RST_LIMIT_CTL      = 8'h00;
	localparam logic [7:0] WMASK_RECOVERY     = 8'h90;
	localparam logic [7:0] WMASK_LIMIT        = 8'h1F;
	localparam logic [7:0] READ_ZERO          = 8'h00;

	// Fault-clear register
	localparam int FAULT_CLEAR_BIT            = 7;

	// Fault report mask bits
	localparam int MSK_THERM_SHUTDOWN         = 7;
	localparam int MSK_LOGIC_UNDER            = 6;
	localparam int MSK_LOGIC_OVER             = 5;
	localparam int MSK_CLOCK_ERROR            = 4;
	localparam int MSK_POWER_UNDER            = 3;
	localparam int MSK_POWER_OVER             = 2;
	localparam int MSK_OFFSET_FAULT           = 1;
	localparam int MSK_OVERCURRENT            = 0;

	// Latch enable, warning and limit report mask bits
	localparam int LEN_LIMIT_FAULT            = 7;
	localparam int LEN_LIMIT_WARN             = 6;
	localparam int LEN_CLOCK_FAULT            = 5;
	localparam int LEN_SHUTDOWN               = 4;
	localparam int LEN_THERM_WARN             = 3;
	localparam int MSK_THERM_WARNING          = 2;
	localparam int MSK_LIMIT_WARNING          = 1;
	localparam int MSK_LIMIT_FAULT            = 0;

	// Recovery control bits
	localparam int RCV_CLOCK_DETECT_LATCH     = 7;
	localparam int RCV_SHUTDOWN_AUTO          = 4;

	// Current limit control bits
	localparam int LIM_LEVEL_HI               = 4;
	localparam int LIM_LEVEL_LO               = 3;
	localparam int LIM_FUNCTION_EN            = 2;
	localparam int LIM_WARNING_EN             = 1;
	localparam int LIM_FAULT_EN               = 0;
	localparam logic [1:0] LEVEL_RESERVED     = 2'h3;

	// Flag vector layout
	localparam int FLG_THERM                  = 0;
	localparam int FLG_LF1                    = 1;
	localparam int FLG_LF2                    = 2;
	localparam int FLG_LW1                    = 3;
	localparam int FLG_LW2                    = 4;
	localparam int FLG_TW_LO                  = 5;
	localparam int FLG_TW_HI                  = 8;
	localparam int FLG_CLOCK                  = 9;
	localparam int FLG_DC1                    = 10;
	localparam int FLG_DC2                    = 11;
	localparam int FLG_OC1                    = 12;
	localparam int FLG_OC2                    = 13;
	localparam int FLG_CDET                   = 14;
	localparam int NUM_FLAGS                  = 15;

endpackage

// [core/fwsc_flag_cell.sv]
// Bank of status flags that either latch or follow their live condition
`timescale 1ns/100ps
module fwsc_flag_cell #(
	parameter int WIDTH = 15
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             nrst,
	// Conditions and controls
	input  wire logic [WIDTH-1:0] liveIn,
	input  wire logic [WIDTH-1:0] latchEn,
	input  wire logic             clearReq,
	// Flags
	output logic      [WIDTH-1:0] flag_q
);
	typedef struct packed {
		logic [WIDTH-1:0] flag;
	} fwsc_cell_state_t;

	fwsc_cell_state_t s_d;
	fwsc_cell_state_t s_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("flag bank needs at least one flag");
	end

	// Set wins over a clear arriving in the same cycle
	always_comb begin
		s_d = s_q;
		s_d.flag = liveIn | (s_q.flag & latchEn & {WIDTH{~clearReq}});
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign flag_q = s_q.flag;

	latch_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		!clearReq |=> ((flag_q & $past(flag_q & latchEn))
			== $past(flag_q & latchEn)))
		else $error("latched flag dropped without a clear");

endmodule

// [verif/fwsc_host_model.sv]
// Host controller model that drives the register port of the slice
`timescale 1ns/100ps
module fwsc_host_model (
	// Clock
	input  wire logic       ref_clk,
	// Register port
	output logic      [7:0] regAddr,
	output logic            regWrite,
	output logic      [7:0] regWrData,
	output logic            regRead,
	input  wire logic [7:0] regRdData_q,
	input  wire logic       regRdValid_q
);
	initial begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regWrData = 8'h00;
		regRead = 1'b0;
	end

	// One-cycle write strobe; data inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regWrData = d;
		regWrite = 1'b1;
		@(negedge ref_clk);
		regWrite = 1'b0;
		regWrData = ~d;
	endtask

	// Read data is taken only while the valid pulse stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge ref_clk);
		regRead = 1'b0;
		regAddr = ~a;
		d = regRdValid_q ? regRdData_q : 8'hXX;
	endtask
endmodule

// [verif/test_fault_warning_status_control.sv]
// Self-checking bench for the protection status and control slice
`timescale 1ns/100ps
module test_fault_warning_status_control;
	import fwsc_pkg::*;
	logic       ref_clk = 1'b0;
	logic       nrst = 1'b0;
	logic [7:0] addr, wrD, rdD;
	logic       wrE, rdE, rdV;
	logic       tin = 1'b0, ce = 1'b0, cd = 1'b0;
	logic [3:0] tw = 4'h0, sup = 4'h0;
	logic [1:0] lf = 2'h0, lw = 2'h0, dc = 2'h0, oc = 2'h0;
	logic       flt, hiz, fne, wne, fle, cds;
	logic [1:0] lvl;
	int         errorCnt = 0;
	int         compares = 0;

	always #5 ref_clk = ~ref_clk;

	fwsc_top fwsc_top_inst (.ref_clk(ref_clk), .nrst(nrst),
		.regAddr(addr), .regWrite(wrE), .regWrData(wrD), .regRead(rdE),
		.regRdData_q(rdD), .regRdValid_q(rdV), .thermShutdownIn(tin),
		.thermWarnIn(tw), .chanLimitFaultIn(lf), .chanLimitWarnIn(lw),
		.clockErrorIn(ce), .clockDetectIn(cd), .chanOffsetFaultIn(dc),
		.chanOverCurrentIn(oc), .logicSupplyUnderIn(sup[3]),
		.logicSupplyOverIn(sup[2]), .powerSupplyUnderIn(sup[1]),
		.powerSupplyOverIn(sup[0]), .faultReport_q(flt),
		.outputHiZ_q(hiz), .limitFunctionEnable_q(fne),
		.limitWarningEnable_q(wne), .limitFaultEnable_q(fle),
		.limitLevelSelect_q(lvl), .clockDetectStatus_q(cds));

	fwsc_host_model fwsc_host_model_inst (.ref_clk(ref_clk),
		.regAddr(addr), .regWrite(wrE), .regWrData(wrD), .regRead(rdE),
		.regRdData_q(rdD), .regRdValid_q(rdV));

	task automatic chk(input string n, input logic [7:0] g,
		input logic [7:0] e);
		compares++;
		if (g !== e) begin
			errorCnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		fwsc_host_model_inst.rd(a, d);
		chk($sformatf("reg%0h", a), d, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		fwsc_host_model_inst.wr(a, d);
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic testReset();
		rdc(8'h72, 8'h00);
		rdc(8'h73, 8'h00);
		rdc(8'h74, 8'h00);
		rdc(8'h75, 8'hF8);
		rdc(8'h76, 8'h00);
		rdc(8'h77, 8'h00);
		chk("en", 8'({fne, wne, fle}), 8'h00);
		rdc(8'h79, 8'h00);
		$display("reset test done");
	endtask

	task automatic testRegs();
		wr(8'h76, 8'hFF);
		rdc(8'h76, 8'h90);
		wr(8'h77, 8'hFF);
		rdc(8'h77, 8'h07);
		chk("en", 8'({fne, wne, fle}), 8'h07);
		wr(8'h77, 8'h0F);
		chk("lvl", 8'(lvl), 8'h01);
		wr(8'h77, 8'h10);
		rdc(8'h77, 8'h10);
		chk("lvl", 8'(lvl), 8'h02);
		wr(8'h72, 8'hFF);
		rdc(8'h72, 8'h00);
		wr(8'h76, 8'h00);
		wr(8'h77, 8'h00);
		$display("register test done");
	endtask

	task automatic testThermal();
		tin = 1'b1;
		tick(3);
		chk("hiz", 8'(hiz), 8'h01);
		chk("flt", 8'(flt), 8'h01);
		tin = 1'b0;
		tick(3);
		rdc(8'h72, 8'h01);
		chk("hiz", 8'(hiz), 8'h01);
		wr(8'h78, 8'h7F);
		rdc(8'h72, 8'h01);
		wr(8'h78, 8'h80);
		rdc(8'h72, 8'h00);
		chk("hiz", 8'(hiz), 8'h00);
		chk("flt", 8'(flt), 8'h00);
		wr(8'h76, 8'h10);
		tin = 1'b1;
		tick(2);
		chk("hiz", 8'(hiz), 8'h01);
		tin = 1'b0;
		tick(2);
		chk("hiz", 8'(hiz), 8'h00);
		wr(8'h78, 8'h80);
		// Shutdown latch off: the flag must follow the condition
		wr(8'h75, 8'hE8);
		tin = 1'b1;
		tick(2);
		rdc(8'h72, 8'h01);
		tin = 1'b0;
		tick(2);
		rdc(8'h72, 8'h00);
		wr(8'h75, 8'hF8);
		wr(8'h76, 8'h00);
		$display("thermal test done");
	endtask

	task automatic testLimit();
		lf = 2'h3;
		lw = 2'h3;
		tw = 4'hF;
		tick(2);
		rdc(8'h72, 8'h00);
		rdc(8'h73, 8'h0F);
		wr(8'h77, 8'h07);
		rdc(8'h72, 8'h06);
		rdc(8'h73, 8'h3F);
		lf = 2'h0;
		lw = 2'h0;
		tw = 4'h0;
		rdc(8'h73, 8'h3F);
		wr(8'h78, 8'h80);
		rdc(8'h73, 8'h00);
		wr(8'h75, 8'h07);
		tw = 4'h5;
		lf = 2'h1;
		tick(3);
		rdc(8'h73, 8'h05);
		chk("flt", 8'(flt), 8'h00);
		tw = 4'h0;
		lf = 2'h0;
		tick(2);
		rdc(8'h73, 8'h00);
		rdc(8'h72, 8'h00);
		wr(8'h75, 8'hF8);
		wr(8'h77, 8'h01);
		lf = 2'h2;
		tick(2);
		rdc(8'h72, 8'h00);
		lf = 2'h0;
		wr(8'h77, 8'h00);
		$display("limiter test done");
	endtask

	task automatic testMasks();
		logic [7:0] m [4] = '{8'h40, 8'h20, 8'h08, 8'h04};
		for (int i = 0; i < 4; i++) begin
			sup = 4'h8 >> i;
			tick(3);
			chk("flt", 8'(flt), 8'h01);
			wr(8'h74, m[i]);
			tick(2);
			chk("flt", 8'(flt), 8'h00);
			sup = 4'h0;
			wr(8'h74, 8'h00);
		end
		wr(8'h74, 8'h03);
		dc = 2'h1;
		oc = 2'h2;
		tick(3);
		chk("hiz", 8'(hiz), 8'h01);
		chk("flt", 8'(flt), 8'h00);
		dc = 2'h0;
		oc = 2'h0;
		wr(8'h74, 8'h00);
		tick(2);
		chk("flt", 8'(flt), 8'h01);
		wr(8'h78, 8'h80);
		tick(2);
		chk("hiz", 8'(hiz), 8'h00);
		wr(8'h74, 8'h10);
		ce = 1'b1;
		tick(3);
		chk("flt", 8'(flt), 8'h00);
		ce = 1'b0;
		wr(8'h78, 8'h80);
		wr(8'h74, 8'h00);
		$display("mask test done");
	endtask

	task automatic testClockDetect();
		cd = 1'b1;
		tick(2);
		chk("cds", 8'(cds), 8'h01);
		cd = 1'b0;
		tick(2);
		chk("cds", 8'(cds), 8'h00);
		wr(8'h76, 8'h80);
		cd = 1'b1;
		tick(2);
		cd = 1'b0;
		tick(2);
		chk("cds", 8'(cds), 8'h01);
		$display("clock detect test done");
	endtask

	// Whole run is well under two thousand cycles
	initial begin
		#200000;
		errorCnt++;
		wrapUp();
	end

	initial begin
		tick(20);
		nrst = 1'b1;
		testReset();
		testRegs();
		testThermal();
		testLimit();
		testMasks();
		testClockDetect();
		wrapUp();
	end
endmodule
